// ==== verilog/srpg_pkg.sv ====
// Package: register map, field positions, reset values and encodings of the pattern generator
package srpg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] SRPG_ADDR_DIV_LO   = 16'h0400;
  localparam logic [15:0] SRPG_ADDR_DIV_HI   = 16'h0401;
  localparam logic [15:0] SRPG_ADDR_CLK_TRIG = 16'h0402;
  localparam logic [15:0] SRPG_ADDR_SRC_PAT  = 16'h0403;

  // ==========================================================================
  // Field positions, clock/trigger control register
  localparam int SRPG_BIT_REQ_METHOD = 7;
  localparam int SRPG_TRIG_HI        = 6;
  localparam int SRPG_TRIG_LO        = 5;
  localparam int SRPG_BIT_GEN_CLK    = 4;
  localparam int SRPG_BIT_RESAMP_CLK = 3;
  localparam int SRPG_TEST_HI        = 2;
  localparam int SRPG_TEST_LO        = 1;
  localparam int SRPG_BIT_GEN_RST    = 0;

  // Field positions, source/pattern control register
  localparam int SRPG_SRC_HI   = 7;
  localparam int SRPG_SRC_LO   = 6;
  localparam int SRPG_MODE_HI  = 5;
  localparam int SRPG_MODE_LO  = 4;
  localparam int SRPG_NSHOT_HI = 3;
  localparam int SRPG_NSHOT_LO = 1;
  localparam int SRPG_BIT_REQ  = 0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SRPG_RST_DIV_LO   = 8'h00;
  localparam logic [7:0] SRPG_RST_DIV_HI   = 8'h00;
  localparam logic [7:0] SRPG_RST_CLK_TRIG = 8'h00;
  localparam logic [7:0] SRPG_RST_SRC_PAT  = 8'h00;
  localparam logic [6:0] SRPG_PRBS_SEED    = 7'h7f;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    SRPG_MODE_NSHOT = 2'b00,
    SRPG_MODE_CONT  = 2'b01,
    SRPG_MODE_PRBS  = 2'b10,
    SRPG_MODE_STOP  = 2'b11
  } srpg_mode_t;

  typedef enum logic [1:0] {
    SRPG_SRC_EXT    = 2'b00,
    SRPG_SRC_RESAMP = 2'b01,
    SRPG_SRC_INT    = 2'b10,
    SRPG_SRC_TEST   = 2'b11
  } srpg_src_t;

  localparam logic [1:0] SRPG_TRIG_RISE = 2'b10;
  localparam logic [1:0] SRPG_TRIG_FALL = 2'b11;
  localparam logic [1:0] SRPG_TEST_LOW  = 2'b00;
  localparam logic [1:0] SRPG_TEST_HIGH = 2'b01;

  typedef enum logic {
    SRPG_ST_IDLE = 1'b0,
    SRPG_ST_RUN  = 1'b1
  } srpg_state_t;

endpackage

// ==== verilog/srpg_div_if.sv ====
// Interface between the pattern controller and the pulse-width divider
`timescale 1ns/10ps
interface srpg_div_if;
  logic        tick;
  logic [15:0] k_div;
  logic        hold;
  logic        div_clk;
  logic        rise;
  logic        fall;
  modport gen (input tick, input k_div, input hold, output div_clk, output rise, output fall);
  modport ctl (output tick, output k_div, output hold, input div_clk, input rise, input fall);
endinterface

// ==== verilog/srpg_pulse_div.sv ====
// Pulse-width divider: each half period of the counter clock lasts K generator ticks
`timescale 1ns/10ps
module srpg_pulse_div
  import srpg_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic reset_n_in,
  // Controller side
  srpg_div_if.gen   dv
);

  logic [15:0] cnt_q, cnt_d;
  logic        clk_q, clk_d;
  logic        rise_q, rise_d;
  logic        fall_q, fall_d;

  // ==========================================================================
  // Divide: K of zero behaves as one so the counter clock never stalls
  always_comb
  begin
    cnt_d  = cnt_q;
    clk_d  = clk_q;
    rise_d = 1'b0;
    fall_d = 1'b0;
    if (dv.hold)
    begin
      cnt_d = 16'h0000;
      clk_d = 1'b0;
    end
    else if (dv.tick)
    begin
      if ((cnt_q + 16'h0001) >= dv.k_div) // [RULE1]
      begin
        cnt_d  = 16'h0000;
        clk_d  = ~clk_q;
        rise_d = ~clk_q;
        fall_d = clk_q;
      end
      else
      begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q  <= 16'h0000;
      clk_q  <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      clk_q  <= clk_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign dv.div_clk = clk_q;
  assign dv.rise    = rise_q;
  assign dv.fall    = fall_q;

  // ==========================================================================
  // Checks
  a_div_hold_low : assert property (@(posedge clk_sys_in) disable iff (!reset_n_in) // [RULE1]
    dv.hold |=> !clk_q && cnt_q == 16'h0000)
    else $error("Divider not cleared by hold");

endmodule // srpg_pulse_div

// ==== verilog/srpg_pattern_gen.sv ====
// Top: SYSREF source selection, pattern generator control and register file
// ============================================================================
// Summary of operation
// RULE1 - Generator clock is divided by a 16-bit value setting each pulse width.
// RULE2 - Divider value: low register gives bits 7..0, next register bits 15..8.
// RULE3 - Request by register bit or pin; pin trigger is high level, rising or falling.
// RULE4 - Generator clock source bit picks feedback divider (0) or first loop (1).
// RULE5 - Resample clock for external SYSREF: device clock (0) or first loop (1).
// RULE6 - Test field forces output low, high, or to the counter clock.
// RULE7 - Source field: external direct, external resampled, or internal generator.
// RULE8 - Pattern mode: fixed count, continuous, pseudo-random, or stop.
// RULE9 - Fixed-count burst starts on request bit rising; count code sets pulses.
// RULE10 - In fixed-count mode the request bit clears itself after the burst.
// RULE11 - Continuous or pseudo-random starts on request rising; bit stays set.
// RULE12 - Clearing the request bit halts a continuous or pseudo-random pattern.
// RULE13 - While the generator reset bit is set the generator idles.
`timescale 1ns/10ps
module srpg_pattern_gen
  import srpg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        reset_n_in,
  // Register port
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [7:0]  reg_rdata_out,
  output logic             reg_rvalid_out,
  // Clock enables from the loops, same clock domain
  input  wire logic        first_loop_output_in,
  input  wire logic        second_loop_feedback_output_in,
  input  wire logic        device_clk_tick_in,
  // Pins
  input  wire logic        ext_sysref_pin_in,
  input  wire logic        request_pin_in,
  output logic             sysref_out
);

  srpg_div_if dv ();

  logic [7:0]  div_lo_q, div_lo_d, div_hi_q, div_hi_d;
  logic [7:0]  ctrl_q, ctrl_d, src_q, src_d;
  logic        req_prev_q;
  logic        ext_m_q, ext_s_q, pin_m_q, pin_s_q, pin_prev_q;
  logic        resamp_q, resamp_d;
  srpg_state_t state_q, state_d;
  logic [3:0]  pcnt_q, pcnt_d;
  logic [6:0]  prbs_q, prbs_d;
  logic        sysref_d;
  logic [7:0]  rdata_d;
  logic        gen_rst, pin_method, start, stop, nshot_done, gen_tick, resamp_tick;
  logic [1:0]  trig;
  logic [3:0]  shot_last;
  srpg_mode_t  mode;
  srpg_src_t   src;

  // Pulses per burst, minus one; unlisted codes give a single pulse
  function automatic logic [3:0] shot_last_of(input logic [2:0] code);
    unique case (code)
      3'b010:  shot_last_of = 4'h1;
      3'b011:  shot_last_of = 4'h3;
      3'b100:  shot_last_of = 4'h5;
      3'b101:  shot_last_of = 4'h7;
      default: shot_last_of = 4'h0;
    endcase
  endfunction

  // ==========================================================================
  // Field decode
  assign gen_rst     = ctrl_q[SRPG_BIT_GEN_RST];
  assign pin_method  = ctrl_q[SRPG_BIT_REQ_METHOD];
  assign trig        = ctrl_q[SRPG_TRIG_HI:SRPG_TRIG_LO];
  assign mode        = srpg_mode_t'(src_q[SRPG_MODE_HI:SRPG_MODE_LO]);
  assign src         = srpg_src_t'(src_q[SRPG_SRC_HI:SRPG_SRC_LO]);
  assign shot_last   = shot_last_of(src_q[SRPG_NSHOT_HI:SRPG_NSHOT_LO]);
  assign gen_tick    = ctrl_q[SRPG_BIT_GEN_CLK] ? first_loop_output_in
                                                : second_loop_feedback_output_in; // [RULE4]
  assign resamp_tick = ctrl_q[SRPG_BIT_RESAMP_CLK] ? first_loop_output_in
                                                   : device_clk_tick_in; // [RULE5]

  // Divider stays in phase reset while idle, except with the test source, so every burst starts aligned
  assign dv.tick  = gen_tick;
  assign dv.k_div = {div_hi_q, div_lo_q}; // [RULE2]
  assign dv.hold  = gen_rst || (state_q == SRPG_ST_IDLE && src != SRPG_SRC_TEST);

  srpg_pulse_div u_div (
    .clk_sys_in (clk_sys_in),
    .reset_n_in (reset_n_in),
    .dv         (dv.gen)
  );

  // ==========================================================================
  // Request detection: register bit edge, or synchronised pin level or edge
  always_comb
  begin
    start = 1'b0;
    stop  = 1'b0;
    if (!pin_method)
    begin
      start = src_q[SRPG_BIT_REQ] && !req_prev_q; // [RULE9] [RULE11]
      stop  = mode != SRPG_MODE_NSHOT && !src_q[SRPG_BIT_REQ]; // [RULE12]
    end
    else if (trig == SRPG_TRIG_RISE)
      start = pin_s_q && !pin_prev_q; // [RULE3]
    else if (trig == SRPG_TRIG_FALL)
      start = !pin_s_q && pin_prev_q; // [RULE3]
    else
    begin
      start = pin_s_q; // [RULE3]
      stop  = mode != SRPG_MODE_NSHOT && !pin_s_q;
    end
  end

  assign nshot_done = state_q == SRPG_ST_RUN && mode == SRPG_MODE_NSHOT
                      && dv.fall && pcnt_q == shot_last;

  // ==========================================================================
  // Generator sequence
  always_comb
  begin
    state_d = state_q;
    pcnt_d  = pcnt_q;
    prbs_d  = prbs_q;
    unique case (state_q)
      SRPG_ST_IDLE:
      begin
        pcnt_d = 4'h0;
        prbs_d = SRPG_PRBS_SEED;
        if (start && mode != SRPG_MODE_STOP)
          state_d = SRPG_ST_RUN;
      end
      SRPG_ST_RUN:
      begin
        if (dv.fall)
          pcnt_d = pcnt_q + 4'h1;
        if (dv.rise)
          prbs_d = {prbs_q[5:0], prbs_q[6] ^ prbs_q[5]};
        if (stop || nshot_done || mode == SRPG_MODE_STOP) // [RULE8] [RULE12]
          state_d = SRPG_ST_IDLE;
      end
    endcase
    if (gen_rst)
      state_d = SRPG_ST_IDLE; // [RULE13]
  end

  // ==========================================================================
  // Output selection and external resampling
  always_comb
  begin
    resamp_d = resamp_tick ? ext_s_q : resamp_q; // [RULE5]
    unique case (src)
      SRPG_SRC_EXT:    sysref_d = ext_s_q; // [RULE7]
      SRPG_SRC_RESAMP: sysref_d = resamp_q; // [RULE7]
      SRPG_SRC_INT:    sysref_d = state_q == SRPG_ST_RUN &&
                                  (mode == SRPG_MODE_PRBS ? prbs_q[0] : dv.div_clk);
      SRPG_SRC_TEST:   sysref_d = trig_test(ctrl_q[SRPG_TEST_HI:SRPG_TEST_LO], dv.div_clk);
    endcase
  end

  // Test override: low, high, or the raw counter clock
  function automatic logic trig_test(input logic [1:0] t, input logic c);
    if (t == SRPG_TEST_LOW)
      trig_test = 1'b0; // [RULE6]
    else if (t == SRPG_TEST_HIGH)
      trig_test = 1'b1; // [RULE6]
    else
      trig_test = c; // [RULE6]
  endfunction

  // ==========================================================================
  // Register writes; a software write of the request bit wins over auto-clear
  always_comb
  begin
    div_lo_d = div_lo_q;
    div_hi_d = div_hi_q;
    ctrl_d   = ctrl_q;
    src_d    = src_q;
    if (nshot_done && !pin_method)
      src_d[SRPG_BIT_REQ] = 1'b0; // [RULE10]
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        SRPG_ADDR_DIV_LO:   div_lo_d = reg_wdata_in; // [RULE2]
        SRPG_ADDR_DIV_HI:   div_hi_d = reg_wdata_in; // [RULE2]
        SRPG_ADDR_CLK_TRIG: ctrl_d   = reg_wdata_in;
        SRPG_ADDR_SRC_PAT:  src_d    = reg_wdata_in;
        default:            ;
      endcase
    end
    unique case (reg_addr_in)
      SRPG_ADDR_DIV_LO:   rdata_d = div_lo_q;
      SRPG_ADDR_DIV_HI:   rdata_d = div_hi_q;
      SRPG_ADDR_CLK_TRIG: rdata_d = ctrl_q;
      SRPG_ADDR_SRC_PAT:  rdata_d = src_q;
      default:            rdata_d = 8'h00;
    endcase
  end

  // ==========================================================================
  // State registers; pins pass two flops before any logic reads them
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      div_lo_q       <= SRPG_RST_DIV_LO;
      div_hi_q       <= SRPG_RST_DIV_HI;
      ctrl_q         <= SRPG_RST_CLK_TRIG;
      src_q          <= SRPG_RST_SRC_PAT;
      req_prev_q     <= 1'b0;
      ext_m_q        <= 1'b0;
      ext_s_q        <= 1'b0;
      pin_m_q        <= 1'b0;
      pin_s_q        <= 1'b0;
      pin_prev_q     <= 1'b0;
      resamp_q       <= 1'b0;
      state_q        <= SRPG_ST_IDLE;
      pcnt_q         <= 4'h0;
      prbs_q         <= SRPG_PRBS_SEED;
      sysref_out     <= 1'b0;
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else
    begin
      div_lo_q       <= div_lo_d;
      div_hi_q       <= div_hi_d;
      ctrl_q         <= ctrl_d;
      src_q          <= src_d;
      req_prev_q     <= src_q[SRPG_BIT_REQ];
      ext_m_q        <= ext_sysref_pin_in;
      ext_s_q        <= ext_m_q;
      pin_m_q        <= request_pin_in;
      pin_s_q        <= pin_m_q;
      pin_prev_q     <= pin_s_q;
      resamp_q       <= resamp_d;
      state_q        <= state_d;
      pcnt_q         <= pcnt_d;
      prbs_q         <= prbs_d;
      sysref_out     <= sysref_d;
      reg_rdata_out  <= reg_rd_in ? rdata_d : 8'h00;
      reg_rvalid_out <= reg_rd_in;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);

  a_nshot_autoclear : assert property (nshot_done && !pin_method && !reg_wr_in // [RULE10]
    |=> !src_q[SRPG_BIT_REQ])
    else $error("Request bit not cleared after burst");
  a_reg_start_run : assert property (!pin_method && src_q[SRPG_BIT_REQ] && !req_prev_q // [RULE9]
    && state_q == SRPG_ST_IDLE && mode != SRPG_MODE_STOP && !gen_rst |=> state_q == SRPG_ST_RUN)
    else $error("Register request did not start generator");
  a_cont_req_held : assert property (state_q == SRPG_ST_RUN && mode == SRPG_MODE_CONT // [RULE11]
    && src_q[SRPG_BIT_REQ] && !reg_wr_in |=> src_q[SRPG_BIT_REQ])
    else $error("Request bit dropped in continuous mode");
  a_cont_req_stop : assert property (state_q == SRPG_ST_RUN && !pin_method // [RULE12]
    && mode inside {SRPG_MODE_CONT, SRPG_MODE_PRBS} && !src_q[SRPG_BIT_REQ] |=> state_q == SRPG_ST_IDLE)
    else $error("Pattern did not halt on request clear");
  a_gen_rst_idle : assert property (gen_rst [*2] |-> state_q == SRPG_ST_IDLE // [RULE13]
    && !dv.div_clk)
    else $error("Generator active under its reset bit");
  a_mode_stop : assert property (mode == SRPG_MODE_STOP && $past(mode) == SRPG_MODE_STOP // [RULE8]
    |-> state_q == SRPG_ST_IDLE)
    else $error("Generator running in stop mode");
  a_test_forced : assert property (src == SRPG_SRC_TEST // [RULE6]
    && ctrl_q[SRPG_TEST_HI:SRPG_TEST_LO] == SRPG_TEST_HIGH |=> sysref_out)
    else $error("Test high not forced");
  a_ext_direct : assert property (src == SRPG_SRC_EXT |=> sysref_out == $past(ext_s_q)) // [RULE7]
    else $error("External path mismatch");
  a_resamp_hold : assert property (!resamp_tick |=> $stable(resamp_q)) // [RULE5]
    else $error("Resampler moved without its clock");
  a_rise_on_tick : assert property (dv.rise |-> $past(gen_tick)) // [RULE4]
    else $error("Counter clock moved without generator clock");
  a_pin_rise_start : assert property (pin_method && trig == SRPG_TRIG_RISE && pin_s_q // [RULE3]
    && !pin_prev_q && state_q == SRPG_ST_IDLE && mode != SRPG_MODE_STOP && !gen_rst
    |=> state_q == SRPG_ST_RUN)
    else $error("Pin rising edge did not start generator");
  a_div_bytes : assert property (reg_wr_in && reg_addr_in == SRPG_ADDR_DIV_HI // [RULE2]
    |=> dv.k_div[15:8] == $past(reg_wdata_in))
    else $error("Divider high byte not loaded");

  c_nshot_done : cover property (nshot_done && shot_last == 4'h7);
  c_cont_run   : cover property (state_q == SRPG_ST_RUN && mode == SRPG_MODE_CONT ##1 stop);
  c_prbs_run   : cover property (state_q == SRPG_ST_RUN && mode == SRPG_MODE_PRBS && dv.rise);
  c_pin_start  : cover property (pin_method && start && state_q == SRPG_ST_IDLE);

endmodule // srpg_pattern_gen

// ==== dv/srpg_conv_model.sv ====
// Converter-side model: counts received SYSREF pulses and measures their high time
`timescale 1ns/10ps
module srpg_conv_model
(
  // Clock and control
  input  wire logic       clk_sys_in,
  input  wire logic       clear_in,
  // SYSREF from the generator
  input  wire logic       sysref_in,
  // Observations
  output logic      [7:0] pulse_count_out,
  output logic      [7:0] high_width_out
);
  logic       last_q;
  logic [7:0] run_q;

  // ==========================================================================
  // Edge counter; a converter aligns on rising edges only, so levels are ignored
  always_ff @(posedge clk_sys_in)
  begin
    last_q <= sysref_in;
    if (clear_in)
    begin
      pulse_count_out <= 8'h00;
      high_width_out  <= 8'h00;
      run_q           <= 8'h00;
    end
    else if (sysref_in)
    begin
      run_q <= run_q + 8'h01;
      if (!last_q)
        pulse_count_out <= pulse_count_out + 8'h01;
    end
    else
    begin
      run_q <= 8'h00;
      if (last_q)
        high_width_out <= run_q; // Width of the pulse that just ended
    end
  end
endmodule // srpg_conv_model

// ==== dv/tb.sv ====
// Self-checking testbench for the SYSREF pattern generator
`timescale 1ns/10ps
module tb
  import srpg_pkg::*;
;
  logic        clk_sys_in;
  logic        reset_n_in;
  logic [15:0] reg_addr_in;
  logic [7:0]  reg_wdata_in;
  logic        reg_wr_in;
  logic        reg_rd_in;
  logic [7:0]  reg_rdata_out;
  logic        reg_rvalid_out;
  logic        first_loop_q;
  logic        second_loop_q;
  logic        dev_tick_q;
  logic        ext_pin_q;
  logic        req_pin_q;
  logic        sysref_out;
  logic        clear_q;
  logic [7:0]  cnt;
  logic [7:0]  width;
  logic [7:0]  v;
  logic [7:0]  c_hi;
  int          num_errors;
  int          checks_done;
  // Burst lengths by count code, unknown codes give one pulse
  logic [7:0]  nshot_len [8] = '{8'h01, 8'h01, 8'h02, 8'h04, 8'h06, 8'h08, 8'h01, 8'h01};

  // ==========================================================================
  // Clock, reset and loop enables; first loop runs at half rate so widths differ
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} = '0;
    // Feedback and device enables tick every cycle, pins idle low, model held clear
    {first_loop_q, second_loop_q, dev_tick_q, ext_pin_q, req_pin_q, clear_q} = 6'h19;
    reset_n_in = 1'b0;
  end
  always @(posedge clk_sys_in)
    first_loop_q <= ~first_loop_q;

  srpg_pattern_gen dut (
    .clk_sys_in                     (clk_sys_in),
    .reset_n_in                     (reset_n_in),
    .reg_addr_in                    (reg_addr_in),
    .reg_wdata_in                   (reg_wdata_in),
    .reg_wr_in                      (reg_wr_in),
    .reg_rd_in                      (reg_rd_in),
    .reg_rdata_out                  (reg_rdata_out),
    .reg_rvalid_out                 (reg_rvalid_out),
    .first_loop_output_in           (first_loop_q),
    .second_loop_feedback_output_in (second_loop_q),
    .device_clk_tick_in             (dev_tick_q),
    .ext_sysref_pin_in              (ext_pin_q),
    .request_pin_in                 (req_pin_q),
    .sysref_out                     (sysref_out)
  );
  srpg_conv_model conv (
    .clk_sys_in      (clk_sys_in),
    .clear_in        (clear_q),
    .sysref_in       (sysref_out),
    .pulse_count_out (cnt),
    .high_width_out  (width)
  );

  // ==========================================================================
  // Access tasks; each starts on a fresh edge so strobes never clash
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
    #1;
    chk("read valid", 8'h01, {7'h00, reg_rvalid_out});
    d = reg_rdata_out;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic clr;
    @(posedge clk_sys_in);
    clear_q <= 1'b1;
    @(posedge clk_sys_in);
    clear_q <= 1'b0;
  endtask
  // Fixed-count burst: wait for the self-clearing request bit, bounded
  task automatic burst(input logic [7:0] ctl, input logic [7:0] n, input logic [7:0] w);
    int i;
    clr();
    wr(SRPG_ADDR_SRC_PAT, ctl);
    v = 8'h01;
    for (i = 0; i < 200 && v[0] === 1'b1; i++)
      rd(SRPG_ADDR_SRC_PAT, v);
    idle(4);
    #1;
    chk("request bit", 8'h00, {7'h00, v[0]});
    chk("pulse count", n, cnt);
    chk("pulse width", w, width);
  endtask
  // Free-running pattern: bit stays set, clearing it halts the output
  task automatic run_stop(input logic [7:0] ctl);
    clr();
    wr(SRPG_ADDR_SRC_PAT, ctl);
    idle(60);
    rd(SRPG_ADDR_SRC_PAT, v);
    chk("request held", 8'h01, {7'h00, v[0]});
    chk("running", 8'h01, {7'h00, cnt != 8'h00});
    wr(SRPG_ADDR_SRC_PAT, ctl & 8'hfe);
    idle(12);
    clr();
    idle(40);
    chk("halted count", 8'h00, cnt);
    chk("halted out", 8'h00, {7'h00, sysref_out});
  endtask
  // Pin request: returns pulses seen while high, checks the total after release unless lo_n is 8'hff
  task automatic pin_run(input logic [7:0] ctl, input logic [7:0] lo_n);
    wr(SRPG_ADDR_CLK_TRIG, ctl);
    clr();
    req_pin_q <= 1'b1;
    idle(30);
    c_hi = cnt;
    req_pin_q <= 1'b0;
    idle(30);
    if (lo_n != 8'hff)
      chk("pin pulses", lo_n, cnt);
  endtask
  task automatic out_is(input logic e);
    idle(6);
    #1;
    chk("sysref level", {7'h00, e}, {7'h00, sysref_out});
  endtask
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog sized well above the sequence length
  initial
  begin
    #2000000;
    num_errors++;
    summarize();
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    num_errors  = 0;
    checks_done = 0;
    idle(2);
    reset_n_in <= 1'b1;
    for (int a = 0; a < 4; a++)
    begin
      rd(SRPG_ADDR_DIV_LO + 16'(a), v);
      chk("reset value", 8'h00, v);
    end
    wr(16'h0404, 8'hff);
    rd(16'h0404, v);
    chk("unmapped", 8'h00, v);
    wr(SRPG_ADDR_DIV_HI, 8'ha5);
    rd(SRPG_ADDR_DIV_HI, v);
    chk("divider high", 8'ha5, v);
    wr(SRPG_ADDR_DIV_HI, 8'h00);
    wr(SRPG_ADDR_DIV_LO, 8'h02);
    for (int c = 0; c < 8; c++)
      burst({4'h8, c[2:0], 1'b1}, nshot_len[c], 8'h02);
    wr(SRPG_ADDR_DIV_LO, 8'h03);
    burst(8'h83, 8'h01, 8'h03);
    wr(SRPG_ADDR_CLK_TRIG, 8'h10);
    burst(8'h83, 8'h01, 8'h06);
    wr(SRPG_ADDR_CLK_TRIG, 8'h00);
    run_stop(8'h91);
    run_stop(8'ha1);
    clr();
    wr(SRPG_ADDR_SRC_PAT, 8'hb1);
    idle(40);
    chk("stop mode", 8'h00, cnt);
    wr(SRPG_ADDR_SRC_PAT, 8'h82);
    wr(SRPG_ADDR_CLK_TRIG, 8'h01);
    wr(SRPG_ADDR_SRC_PAT, 8'h83);
    idle(40);
    chk("held in reset", 8'h00, cnt);
    wr(SRPG_ADDR_SRC_PAT, 8'h82);
    pin_run(8'hc0, 8'h01);
    chk("rise while high", 8'h01, c_hi);
    pin_run(8'he0, 8'h01);
    chk("fall while high", 8'h00, c_hi);
    pin_run(8'h80, 8'hff);
    chk("level retrigger", 8'h01, {7'h00, c_hi > 8'h01});
    wr(SRPG_ADDR_SRC_PAT, 8'hc0);
    wr(SRPG_ADDR_CLK_TRIG, 8'h02);
    out_is(1'b1);
    wr(SRPG_ADDR_CLK_TRIG, 8'h00);
    out_is(1'b0);
    wr(SRPG_ADDR_CLK_TRIG, 8'h04);
    clr();
    idle(40);
    chk("counter clock", 8'h01, {7'h00, cnt > 8'h02});
    for (int s = 0; s < 3; s++)
    begin
      wr(SRPG_ADDR_CLK_TRIG, (s == 2) ? 8'h08 : 8'h00);
      wr(SRPG_ADDR_SRC_PAT, (s == 0) ? 8'h00 : 8'h40);
      // Device enable stops when the first loop resamples, so a wrong select shows
      dev_tick_q <= (s != 2);
      ext_pin_q <= 1'b1;
      out_is(1'b1);
      ext_pin_q <= 1'b0;
      out_is(1'b0);
    end
    summarize();
  end
endmodule // tb
